/* File: rtl/scl_fifo.sv */
// flip-flop fifo with stream write side and plain read side
`timescale 1ns/1ps
module scl_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  scl_stream_if.snk wr,
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("scl_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  // full and empty come straight from the occupancy count
  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd_valid = (count != '0);
  assign rd_data = mem[rd_ptr];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = rd_valid && rd_ready;

  // storage written by index, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= wr.data;
  end

  // pointers and count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule : scl_fifo

/* File: rtl/scl_loader.sv */
// serial configuration loader: spi flash read, serial prom and daisy chain
// Summary of operation
// - after own image, forward further data on data out at falling edge
// - after loading, user may keep clocking extra data from the memory
// - mode code 001 loads the image from an spi flash
// - spi mode drives the internally generated shift clock to the flash
// - variant straps choose the read opcode and dummy byte count
// - variant 111 sends opcode 0b then skips one dummy byte
// - variant 101 sends opcode 03 with no dummy bytes
// - variant 110 sends opcode e8 then skips four dummy bytes
// - straps are sampled when the init indicator rises high
// - start at slowest shift clock, speed up only if image asks
`timescale 1ns/1ps
module scl_loader #(
  parameter logic [31:0] IMAGE_BYTES = scl_pkg::IMAGE_BYTES_DEFAULT,
  parameter logic [31:0] CHAIN_BYTES = scl_pkg::CHAIN_BYTES_DEFAULT,
  parameter logic [scl_pkg::ADDR_W-1:0] START_ADDR =
    scl_pkg::START_ADDR_DEFAULT,
  parameter int FIFO_DEPTH = scl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic init_high,
  input wire logic [2:0] mode_straps,
  input wire logic [2:0] flash_variant_straps,
  input wire logic user_continue,
  output logic config_shift_clock,
  output logic spi_select_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic chain_dout,
  output logic config_done,
  output logic variant_error,
  output logic [scl_pkg::RATE_W-1:0] clock_rate_setting,
  output logic cfg_valid,
  output logic [scl_pkg::DATA_W-1:0] cfg_data,
  input wire logic cfg_ready
);
  generate
    if (IMAGE_BYTES == 32'h0)
    begin : g_bad_image
      $error("scl_loader image must hold at least one byte");
    end
  endgenerate
  typedef enum logic [2:0] {
    SCL_IDLE = 3'h0,
    SCL_SEND = 3'h1,
    SCL_DATA = 3'h2,
    SCL_DONE = 3'h3,
    SCL_HALT = 3'h4
  } scl_state_t;
  scl_state_t state;
  logic init_q, first_byte, fwd_bit, fwd_pend, push_valid;
  logic tick, rise, fall, stall, forwarding;
  logic [7:0] div_cnt, half_lim, rx_sh, push_data, next_rx;
  logic [31:0] tx_sh, byte_cnt;
  logic [6:0] hdr_left;
  logic [2:0] bit_cnt;
  logic fifo_rd_valid, fifo_rd_ready;
  logic [7:0] fifo_rd_data;
  scl_stream_if #(.W(scl_pkg::DATA_W)) push_if ();
  assign push_if.valid = push_valid;
  assign push_if.data = push_data;
  // half-period divider; a stalled rise waits for the next tick
  assign tick = (div_cnt >= half_lim - 8'h01);
  assign forwarding = (byte_cnt >= IMAGE_BYTES) && !config_done;
  // hold the clock high-to-low only; a full fifo blocks the byte's last rise
  assign stall = (bit_cnt == 3'h7) && push_valid;
  assign rise = tick && !config_shift_clock && !stall &&
    (state == SCL_SEND || state == SCL_DATA);
  assign fall = tick && config_shift_clock;
  assign next_rx = {rx_sh[6:0], spi_miso};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div_cnt <= 8'h00;
    else if (tick)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // shift clock made from the internal divider and driven out
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      config_shift_clock <= 1'b0;
    else if (rise || fall)
      config_shift_clock <= !config_shift_clock;
  end
  // init rise detector and main sequencer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      init_q <= 1'b0;
      state <= SCL_IDLE;
      spi_select_n <= 1'b1;
      tx_sh <= 32'h0;
      hdr_left <= 7'h00;
      config_done <= 1'b0;
      variant_error <= 1'b0;
    end
    else
    begin
      init_q <= init_high;
      case (state)
        SCL_IDLE:
        begin
          // straps taken on the init rising edge
          if (init_high && !init_q)
          begin
            if (mode_straps == scl_pkg::MODE_SPI_FLASH)
            begin
              state <= SCL_SEND;
              spi_select_n <= 1'b0;
              case (flash_variant_straps)
                scl_pkg::VAR_FAST_READ:
                begin
                  tx_sh <= {scl_pkg::OP_FAST_READ, START_ADDR};
                  hdr_left <= scl_pkg::HDR_BITS +
                    {1'b0, scl_pkg::DUMMY_FAST_READ, 3'h0};
                end
                scl_pkg::VAR_PLAIN_READ:
                begin
                  tx_sh <= {scl_pkg::OP_PLAIN_READ, START_ADDR};
                  hdr_left <= scl_pkg::HDR_BITS +
                    {1'b0, scl_pkg::DUMMY_PLAIN_READ, 3'h0};
                end
                scl_pkg::VAR_ARRAY_READ:
                begin
                  tx_sh <= {scl_pkg::OP_ARRAY_READ, START_ADDR};
                  hdr_left <= scl_pkg::HDR_BITS +
                    {1'b0, scl_pkg::DUMMY_ARRAY_READ, 3'h0};
                end
                default:
                begin
                  state <= SCL_HALT;
                  spi_select_n <= 1'b1;
                  variant_error <= 1'b1;
                end
              endcase
            end
            else if (mode_straps == scl_pkg::MODE_MASTER_SERIAL)
              state <= SCL_DATA; // prom streams from its reset address
          end
        end
        SCL_SEND:
        begin
          // header msb first, changed on falling edges
          if (fall)
            tx_sh <= {tx_sh[30:0], 1'b0};
          if (rise && hdr_left == 7'h01)
            state <= SCL_DATA;
          if (rise)
            hdr_left <= hdr_left - 7'h01;
        end
        SCL_DATA:
        begin
          // loading ends after image and chain bytes
          if (rise && bit_cnt == 3'h7 && !config_done &&
              byte_cnt + 32'h1 >= IMAGE_BYTES + CHAIN_BYTES)
          begin
            state <= SCL_DONE;
            config_done <= 1'b1;
          end
          else if (config_done && !user_continue && bit_cnt == 3'h0 &&
                   !config_shift_clock)
            state <= SCL_DONE;
        end
        SCL_DONE:
        begin
          // user logic keeps reading from the memory
          if (user_continue)
            state <= SCL_DATA;
          else if (!config_shift_clock)
            spi_select_n <= 1'b1;
        end
        SCL_HALT:
          state <= SCL_HALT;
        default:
          state <= SCL_IDLE;
      endcase
    end
  end

  // receive bytes on each rise while in the data state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
      byte_cnt <= 32'h0;
      fwd_bit <= 1'b0;
      fwd_pend <= 1'b0;
    end
    else if (rise && state == SCL_DATA)
    begin
      rx_sh <= next_rx;
      bit_cnt <= bit_cnt + 3'h1;
      fwd_bit <= spi_miso;
      fwd_pend <= forwarding;
      if (bit_cnt == 3'h7 && !config_done)
        byte_cnt <= byte_cnt + 32'h1;
    end
    else if (fall)
      fwd_pend <= 1'b0;
  end
  // chained data changes on the falling shift clock edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      chain_dout <= 1'b0;
    else if (fall && fwd_pend)
      chain_dout <= fwd_bit;
  end
  // own image bytes and post-load user bytes go to the fifo
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      push_valid <= 1'b0;
      push_data <= 8'h00;
    end
    else if (rise && state == SCL_DATA && bit_cnt == 3'h7 &&
             (config_done || byte_cnt < IMAGE_BYTES))
    begin
      push_valid <= 1'b1;
      push_data <= next_rx;
    end
    else if (push_if.ready)
      push_valid <= 1'b0;
  end
  // slow until the first image byte asks for a faster rate
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      first_byte <= 1'b1;
      clock_rate_setting <= scl_pkg::RATE_RESET;
      half_lim <= scl_pkg::SLOW_HALF_CYC;
    end
    else if (rise && state == SCL_DATA && bit_cnt == 3'h7 && first_byte)
    begin
      first_byte <= 1'b0;
      clock_rate_setting <=
        next_rx[scl_pkg::RATE_LSB +: scl_pkg::RATE_W];
      half_lim <= scl_pkg::SLOW_HALF_CYC >>
        next_rx[scl_pkg::RATE_LSB +: scl_pkg::RATE_W];
    end
  end
  // mosi is registered from the header register's top bit, low in idle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      spi_mosi <= 1'b0;
    else
      spi_mosi <= (state == SCL_IDLE) ? 1'b0 : tx_sh[31];
  end
  scl_fifo #(.W(scl_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .wr(push_if),
    .rd_valid(fifo_rd_valid),
    .rd_data(fifo_rd_data),
    .rd_ready(fifo_rd_ready)
  );
  // registered output stage so the user port comes from flip-flops
  assign fifo_rd_ready = !cfg_valid || cfg_ready;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_valid <= 1'b0;
      cfg_data <= 8'h00;
    end
    else if (fifo_rd_ready)
    begin
      cfg_valid <= fifo_rd_valid;
      cfg_data <= fifo_rd_data;
    end
  end
endmodule : scl_loader

/* File: rtl/scl_pkg.sv */
// constants shared by the serial configuration loader files
package scl_pkg;
  // mode strap codes
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_SPI_FLASH = 3'h1;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
  // flash variant codes, opcodes and dummy byte counts
  localparam logic [2:0] VAR_FAST_READ = 3'h7;
  localparam logic [2:0] VAR_PLAIN_READ = 3'h5;
  localparam logic [2:0] VAR_ARRAY_READ = 3'h6;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_PLAIN_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_READ = 8'he8;
  localparam logic [2:0] DUMMY_FAST_READ = 3'h1;
  localparam logic [2:0] DUMMY_PLAIN_READ = 3'h0;
  localparam logic [2:0] DUMMY_ARRAY_READ = 3'h4;
  // header: opcode plus 24-bit address
  localparam int ADDR_W = 24;
  localparam logic [6:0] HDR_BITS = 7'h20;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  // clock rate field in the first image byte
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 2;
  localparam logic [RATE_W-1:0] RATE_RESET = 2'h0;
  // timing: 50 MHz system clock, slowest shift clock 1 us period
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOW_SCK_PERIOD_NS = 1000;
  localparam int SLOW_HALF_CYC_INT =
    (SLOW_SCK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
    (SLOW_SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] SLOW_HALF_CYC = 8'(SLOW_HALF_CYC_INT);
  // default parameter values
  localparam logic [31:0] IMAGE_BYTES_DEFAULT = 32'h00011bdc;
  localparam logic [31:0] CHAIN_BYTES_DEFAULT = 32'h00000000;
  localparam logic [ADDR_W-1:0] START_ADDR_DEFAULT = 24'h000000;
endpackage : scl_pkg

/* File: rtl/scl_stream_if.sv */
// valid/ready byte stream between loader and fifo
`timescale 1ns/1ps
interface scl_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : scl_stream_if

/* File: sim/scl_flash_model.sv */
// behavioural spi flash and serial prom answering the loader
`timescale 1ns/1ps
module scl_flash_model (
  input wire logic config_shift_clock,
  input wire logic spi_select_n,
  input wire logic spi_mosi,
  input wire logic prom_mode,
  input wire logic [1:0] rate_req,
  output logic spi_miso
);
  logic [31:0] hdr;
  int nrise;
  int skip;
  initial spi_miso = 1'b0;
  // stored image: byte 0 carries the requested shift clock rate
  function automatic logic [7:0] pat(input int i);
    logic [7:0] b;
    b = 8'ha1 + 8'(i) * 8'h13;
    if (i == 0)
      b[1:0] = rate_req;
    return b;
  endfunction : pat
  // outside data time the line toggles, so nothing passes by luck
  function automatic logic bit_at(input int n);
    logic [7:0] b;
    b = pat((n - skip) / 8);
    return n < skip ? ~spi_miso : b[7 - (n - skip) % 8];
  endfunction : bit_at
  // a new read starts at select or when prom output is enabled
  always @(negedge spi_select_n or posedge prom_mode)
  begin
    nrise = 0;
    skip = prom_mode ? 0 : 999;
    spi_miso = bit_at(0);
  end
  always @(posedge config_shift_clock)
    if (!spi_select_n || prom_mode)
    begin
      hdr = {hdr[30:0], spi_mosi};
      nrise = nrise + 1;
      if (!prom_mode && nrise == 32)
        skip = hdr[23:0] != 24'h0 ? 999 :
          hdr[31:24] == 8'h0b ? 40 :
          hdr[31:24] == 8'h03 ? 32 :
          hdr[31:24] == 8'he8 ? 64 : 999;
    end
  // serves while clocked, done or not
  always @(negedge config_shift_clock or posedge spi_select_n)
    spi_miso = !spi_select_n || prom_mode ? bit_at(nrise) : ~spi_miso;
endmodule : scl_flash_model

/* File: sim/scl_loader_checker.sv */
// port-level assertions for the serial configuration loader
`timescale 1ns/1ps
module scl_loader_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic init_high,
  input wire logic [2:0] mode_straps,
  input wire logic [2:0] flash_variant_straps,
  input wire logic config_shift_clock,
  input wire logic spi_select_n,
  input wire logic spi_mosi,
  input wire logic chain_dout,
  input wire logic config_done,
  input wire logic variant_error,
  input wire logic [scl_pkg::RATE_W-1:0] clock_rate_setting,
  input wire logic cfg_valid,
  input wire logic [scl_pkg::DATA_W-1:0] cfg_data,
  input wire logic cfg_ready
);
  logic spi, vs_ok;
  logic [7:0] hi_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  assign spi = mode_straps == scl_pkg::MODE_SPI_FLASH;
  // defined codes are 101, 110 and 111: bit 2 set, not 100
  assign vs_ok = flash_variant_straps[2] && flash_variant_straps != 3'h4;
  // high time of the shift clock, checked at each fall
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= config_shift_clock ? hi_cnt + 8'h01 : 8'h00;
  a_select_on_init: assert property ($rose(init_high) && spi && vs_ok
    && spi_select_n && !config_done |=> !spi_select_n)
    else $error("select not low after init rise");
  a_reserved_flag: assert property ($rose(init_high) && spi && !vs_ok
    && spi_select_n && !config_done |=> variant_error)
    else $error("reserved variant not flagged");
  a_error_quiet: assert property (variant_error
    |-> spi_select_n && !config_shift_clock)
    else $error("link active after reserved variant");
  a_select_holds: assert property (!spi_select_n && !config_done
    |=> !spi_select_n)
    else $error("select released before done");
  a_half_period: assert property ($fell(config_shift_clock)
    |-> hi_cnt == scl_pkg::SLOW_HALF_CYC
    || hi_cnt == (scl_pkg::SLOW_HALF_CYC >> clock_rate_setting))
    else $error("shift clock high time wrong");
  // mosi moves only while clock low
  a_mosi_steady: assert property (config_shift_clock
    && $past(config_shift_clock) |-> $stable(spi_mosi))
    else $error("mosi changed while clock high");
  // chain data moves on falling edge
  a_dout_steady: assert property (config_shift_clock
    && $past(config_shift_clock) |-> $stable(chain_dout))
    else $error("chain data changed while clock high");
  a_done_sticks: assert property (config_done |=> config_done)
    else $error("done dropped");
  a_stream_holds: assert property (cfg_valid && !cfg_ready
    |=> cfg_valid && $stable(cfg_data))
    else $error("stream byte not held");
endmodule : scl_loader_checker

bind scl_loader scl_loader_checker i_chk (.clk, .reset_n, .init_high,
  .mode_straps, .flash_variant_straps, .config_shift_clock, .spi_select_n,
  .spi_mosi, .chain_dout, .config_done, .variant_error, .clock_rate_setting,
  .cfg_valid, .cfg_data, .cfg_ready);

/* File: sim/test_scl_loader.sv */
// self-checking bench for the serial configuration loader
`timescale 1ns/1ps
module test_scl_loader;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic init_high = 1'b0;
  logic user_continue = 1'b0;
  logic cfg_ready = 1'b0;
  logic prom_mode = 1'b0;
  logic [1:0] rate_req = 2'h1;
  logic [2:0] mode_straps = 3'h0;
  logic [2:0] flash_variant_straps = 3'h0;
  logic config_shift_clock, spi_select_n, spi_mosi, spi_miso, chain_dout;
  logic config_done, variant_error, cfg_valid, sck_q, sel_seen;
  logic [scl_pkg::RATE_W-1:0] clock_rate_setting;
  logic [scl_pkg::DATA_W-1:0] cfg_data;
  logic [15:0] chain;
  int nr, c0, hi, sf, cyc, first_hi, last_hi, n_errors, check_count;
  always #10 clk = ~clk;
  scl_loader #(.IMAGE_BYTES(32'h4), .CHAIN_BYTES(32'h2)) i_dut (.clk,
    .reset_n, .init_high, .mode_straps, .flash_variant_straps,
    .user_continue, .config_shift_clock, .spi_select_n, .spi_mosi,
    .spi_miso, .chain_dout, .config_done, .variant_error,
    .clock_rate_setting, .cfg_valid, .cfg_data, .cfg_ready);
  // the test access chain is board wiring outside this block
  scl_flash_model i_mem (.config_shift_clock, .spi_select_n, .spi_mosi,
    .prom_mode, .rate_req, .spi_miso);
  // stored image; byte 0 carries the requested shift clock rate
  function automatic logic [7:0] pat(input int i);
    logic [7:0] b;
    b = 8'ha1 + 8'(i) * 8'h13;
    if (i == 0)
      b[1:0] = rate_req;
    return b;
  endfunction : pat
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $realtime, got, exp);
    end
  endtask : chk
  // clock widths, select activity and chain bits 3 clk after each fall
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      stop_test;
    end
    sf++;
    if (config_shift_clock)
      hi++;
    if (config_shift_clock && !sck_q)
      nr++;
    if (!config_shift_clock && sck_q)
    begin
      if (nr == 1)
        first_hi = hi;
      last_hi = hi;
      hi = 0;
      sf = 0;
    end
    if (sf == 3 && nr > c0 && nr <= c0 + 16)
      chain = {chain[14:0], chain_dout};
    if (spi_select_n === 1'b0)
      sel_seen = 1'b1;
    sck_q = config_shift_clock;
  end
  // one stream byte, taken at the edge where valid and ready meet
  task automatic take(input int i);
    do @(posedge clk);
    while (!(cfg_valid === 1'b1 && cfg_ready));
    chk(cfg_data, pat(i));
  endtask : take
  // one load per reset; hdr counts header and dummy bits, -1 if no load
  task automatic run(input logic [2:0] m, input logic [2:0] v,
    input int hdr, input logic uc);
    int t;
    int i;
    #1 reset_n = 1'b0;
    init_high = 1'b0;
    prom_mode = 1'b0;
    mode_straps = m;
    flash_variant_straps = v;
    rate_req = (v == scl_pkg::VAR_PLAIN_READ) ? 2'h2 :
      (m == scl_pkg::MODE_MASTER_SERIAL) ? 2'h0 : 2'h1;
    user_continue = uc;
    cfg_ready = !uc;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    nr = 0;
    hi = 0;
    sel_seen = 1'b0;
    c0 = hdr + 32;
    @(posedge clk);
    #1 init_high = 1'b1;
    prom_mode = m == scl_pkg::MODE_MASTER_SERIAL;
    if (hdr < 0)
    begin
      repeat (200) @(posedge clk);
      chk(variant_error, m == scl_pkg::MODE_SPI_FLASH);
      chk(16'(nr) | sel_seen, 16'h0);
      return;
    end
    if (uc)
    begin
      // fifo full must stall the link, never drop a byte
      repeat (12000) @(posedge clk);
      i = nr;
      repeat (300) @(posedge clk);
      chk(16'(nr), 16'(i));
      #1 cfg_ready = 1'b1;
    end
    for (i = 0; i < 4; i++)
      take(i);
    t = 0;
    while (config_done !== 1'b1 && t < 5000)
    begin
      @(posedge clk);
      t++;
    end
    if (uc)
    begin
      for (i = 6; i < 12; i++)
        take(i);
      #1 user_continue = 1'b0;
      t = 0;
      while (t < 400)
      begin
        @(posedge clk);
        t++;
        if (cfg_valid === 1'b1)
        begin
          chk(cfg_data, pat(i));
          i++;
          t = 0;
        end
      end
      chk(cfg_valid, 1'b0);
    end
    t = 0;
    while (spi_select_n !== 1'b1 && t < 5000)
    begin
      @(posedge clk);
      t++;
    end
    repeat (30) @(posedge clk);
    chk(config_done, 1'b1);
    chk(spi_select_n, 1'b1);
    chk(sel_seen, m == scl_pkg::MODE_SPI_FLASH);
    chk(chain, {pat(4), pat(5)});
    chk(16'(first_hi), 16'(scl_pkg::SLOW_HALF_CYC));
    chk(16'(last_hi), 16'(scl_pkg::SLOW_HALF_CYC >> rate_req));
    chk(clock_rate_setting, rate_req);
  endtask : run
  initial
  begin
    // loading runs strap only the defined variant codes
    run(scl_pkg::MODE_SPI_FLASH, scl_pkg::VAR_FAST_READ, 40, 1'b0);
    run(scl_pkg::MODE_SPI_FLASH, scl_pkg::VAR_PLAIN_READ, 32, 1'b0);
    run(scl_pkg::MODE_SPI_FLASH, scl_pkg::VAR_ARRAY_READ, 64, 1'b1);
    run(scl_pkg::MODE_MASTER_SERIAL, 3'h7, 0, 1'b0);
    for (int v = 0; v < 5; v++)
      run(scl_pkg::MODE_SPI_FLASH, 3'(v), -1, 1'b0);
    run(scl_pkg::MODE_SLAVE_SERIAL, scl_pkg::VAR_FAST_READ, -1, 1'b0);
    stop_test;
  end
endmodule : test_scl_loader
